// ### inc/nbp_pkg.sv
// Constants, types and register map of the NAND bus host controller
package nbp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int PULSE_NS = 25;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int WB_NS = 100;
  localparam int WB_CYC = (WB_NS * CLK_MHZ + 999) / 1000;
  localparam int ARRAY_TRANSFER_TIME_US = 25;
  localparam int ARRAY_TRANSFER_CYC = ARRAY_TRANSFER_TIME_US * CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, word index = byte address [4:2]
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_CMD = 3'h1;
  localparam logic [2:0] REG_ADDR = 3'h2;
  localparam logic [2:0] REG_DATA = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;
  localparam int CTRL_WP_BIT = 0;
  localparam int CTRL_X16_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_RB_BIT = 1;
  localparam int ST_REFUSED_BIT = 2;
  localparam int ST_TMO_BIT = 3;
  localparam int ST_NSTAT_LSB = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Operation codes written to the command register
  localparam logic [3:0] OP_READ = 4'h1;
  localparam logic [3:0] OP_READ_CB = 4'h2;
  localparam logic [3:0] OP_RAND_OUT = 4'h3;
  localparam logic [3:0] OP_PROG = 4'h4;
  localparam logic [3:0] OP_RAND_IN = 4'h5;
  localparam logic [3:0] OP_CONFIRM = 4'h6;
  localparam logic [3:0] OP_CB_PROG = 4'h7;
  localparam logic [3:0] OP_ERASE = 4'h8;
  localparam logic [3:0] OP_STATUS = 4'h9;
  localparam logic [3:0] OP_READ_WORD = 4'ha;
  localparam logic [3:0] OP_DIN = 4'hb;
  localparam logic [3:0] PARTIAL_MAX = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Flash command bytes
  localparam logic [7:0] NC_READ_SETUP = 8'h00;
  localparam logic [7:0] NC_READ_GO = 8'h30;
  localparam logic [7:0] NC_READ_CB = 8'h35;
  localparam logic [7:0] NC_ROUT_SETUP = 8'h05;
  localparam logic [7:0] NC_ROUT_GO = 8'he0;
  localparam logic [7:0] NC_PROG_SETUP = 8'h80;
  localparam logic [7:0] NC_RAND_IN = 8'h85;
  localparam logic [7:0] NC_PROG_GO = 8'h10;
  localparam logic [7:0] NC_ERASE_SETUP = 8'h60;
  localparam logic [7:0] NC_ERASE_GO = 8'hd0;
  localparam logic [7:0] NC_STATUS = 8'h70;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {UK_CMD, UK_ADDR, UK_DIN, UK_DOUT, UK_WAIT, UK_END} nbp_uk_e;
  typedef struct packed {
    nbp_uk_e kind;
    logic [7:0] val;
  } nbp_uop_s;
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic wp_n;
    logic io_oe;
    logic [15:0] io;
  } nbp_pins_s;
  localparam nbp_pins_s PINS_IDLE = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0000};
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_FETCH = 6'b000010,
    ST_LOW = 6'b000100,
    ST_HIGH = 6'b001000,
    ST_BUSYDLY = 6'b010000,
    ST_WAITRB = 6'b100000
  } nbp_state_e;

endpackage : nbp_pkg

// ### rtl/nbp_host.sv
// NAND flash bus host controller with Avalon-MM register slave
`timescale 1ns/1ps
module nbp_host import nbp_pkg::*; #(
  parameter int P_TR_CYC = ARRAY_TRANSFER_CYC
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output nbp_pins_s o_nand,
  input wire logic [15:0] i_io_in,
  input wire logic i_rb
);

  ////////////////////////////////////////////////////////////////////////////
  // Micro-operation sequences
  function automatic nbp_uop_s mk(input nbp_uk_e k, input logic [7:0] v);
    nbp_uop_s u;
    u.kind = k;
    u.val = v;
    return u;
  endfunction : mk

  function automatic nbp_uop_s uop_at(input logic [3:0] op, input logic [3:0] st);
    nbp_uop_s u;
    u = mk(UK_END, 8'h00);
    case (op)
      OP_READ, OP_READ_CB: begin
        if (st == 4'h0) u = mk(UK_CMD, NC_READ_SETUP);
        else if (st <= 4'h4) u = mk(UK_ADDR, {4'h0, st - 4'h1});
        else if (st == 4'h5) u = mk(UK_CMD, (op == OP_READ) ? NC_READ_GO : NC_READ_CB);
        else if (st == 4'h6) u = mk(UK_WAIT, 8'h00);
      end
      OP_RAND_OUT: begin
        if (st == 4'h0) u = mk(UK_CMD, NC_ROUT_SETUP);
        else if (st <= 4'h2) u = mk(UK_ADDR, {4'h0, st - 4'h1});
        else if (st == 4'h3) u = mk(UK_CMD, NC_ROUT_GO);
      end
      OP_PROG, OP_CB_PROG: begin
        if (st == 4'h0) u = mk(UK_CMD, (op == OP_PROG) ? NC_PROG_SETUP : NC_RAND_IN);
        else if (st <= 4'h4) u = mk(UK_ADDR, {4'h0, st - 4'h1});
      end
      OP_RAND_IN: begin
        if (st == 4'h0) u = mk(UK_CMD, NC_RAND_IN);
        else if (st <= 4'h2) u = mk(UK_ADDR, {4'h0, st - 4'h1});
      end
      OP_CONFIRM: begin
        if (st == 4'h0) u = mk(UK_CMD, NC_PROG_GO);
        else if (st == 4'h1) u = mk(UK_WAIT, 8'h00);
        else if (st == 4'h2) u = mk(UK_CMD, NC_STATUS);
        else if (st == 4'h3) u = mk(UK_DOUT, 8'h00);
      end
      OP_ERASE: begin
        if (st == 4'h0) u = mk(UK_CMD, NC_ERASE_SETUP);
        else if (st <= 4'h2) u = mk(UK_ADDR, {4'h0, st + 4'h1});
        else if (st == 4'h3) u = mk(UK_CMD, NC_ERASE_GO);
        else if (st == 4'h4) u = mk(UK_WAIT, 8'h00);
        else if (st == 4'h5) u = mk(UK_CMD, NC_STATUS);
        else if (st == 4'h6) u = mk(UK_DOUT, 8'h00);
      end
      OP_STATUS: begin
        if (st == 4'h0) u = mk(UK_CMD, NC_STATUS);
        else if (st == 4'h1) u = mk(UK_DOUT, 8'h00);
      end
      OP_READ_WORD: begin
        if (st == 4'h0) u = mk(UK_DOUT, 8'h00);
      end
      OP_DIN: begin
        if (st == 4'h0) u = mk(UK_DIN, 8'h00);
      end
      default: u = mk(UK_END, 8'h00);
    endcase
    return u;
  endfunction : uop_at

  ////////////////////////////////////////////////////////////////////////////
  // State
  nbp_state_e state_r;
  nbp_pins_s pins_r;
  logic [3:0] op_r;
  logic [3:0] step_r;
  logic [15:0] cnt_r;
  logic [15:0] timer_r;
  logic wreq_r;
  logic [31:0] rdata_bus_r;
  logic [1:0] ctrl_r;
  logic [27:0] addr_r;
  logic [15:0] din_r;
  logic [15:0] rdata_r;
  logic [7:0] nstat_r;
  logic refused_r;
  logic tmo_r;
  logic loading_r;
  logic data_seen_r;
  logic cb_r;
  logic status_mode_r;
  logic [3:0] prog_cnt_r;
  logic [15:0] last_row_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire busy = (state_r != ST_IDLE);
  wire req = i_avs_read | i_avs_write;
  wire take = req & wreq_r & (i_avs_read | ~busy);
  wire [2:0] idx = i_avs_address[4:2];
  wire wr_take = take & i_avs_write;
  wire cmd_wr = wr_take & (idx == REG_CMD);
  wire dat_wr = wr_take & (idx == REG_DATA);
  wire stat_wr = wr_take & (idx == REG_STATUS);
  wire [3:0] wop = i_avs_writedata[3:0];
  wire wp_free = ctrl_r[CTRL_WP_BIT];
  wire x16 = ctrl_r[CTRL_X16_BIT];
  wire legal = (wop >= OP_READ) & (wop <= OP_READ_WORD);
  wire modify = (wop == OP_PROG) | (wop == OP_RAND_IN) | (wop == OP_CONFIRM) | (wop == OP_CB_PROG) |
                (wop == OP_ERASE);
  wire bad_confirm = (wop == OP_CONFIRM) & (~loading_r | (~data_seen_r & ~cb_r) |
                                            (prog_cnt_r >= PARTIAL_MAX));
  wire bad_cmd = ~legal | (modify & ~wp_free) |
                 ((wop == OP_RAND_IN) & ~loading_r) | bad_confirm;
  wire bad_din = ~loading_r | ~wp_free;
  wire start_go = (cmd_wr & ~bad_cmd) | (dat_wr & ~bad_din);
  wire [3:0] start_op = dat_wr ? OP_DIN : wop;
  wire refuse_set = (cmd_wr & bad_cmd) | (dat_wr & bad_din);
  wire [15:0] row_w = x16 ? addr_r[26:11] : addr_r[27:12];
  wire [31:0] rd_mux = (idx == REG_CTRL) ? {30'h0, ctrl_r} :
                       (idx == REG_CMD) ? {28'h0, op_r} :
                       (idx == REG_ADDR) ? {4'h0, addr_r} :
                       (idx == REG_DATA) ? {16'h0, rdata_r} :
                       (idx == REG_STATUS) ? {16'h0, nstat_r, 4'h0, tmo_r, refused_r, i_rb, busy} :
                       32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Address bytes, unused positions held low
  wire [7:0] ab0 = addr_r[7:0];
  wire [7:0] ab1 = x16 ? {5'h00, addr_r[10:8]} : {4'h0, addr_r[11:8]};
  wire [7:0] ab2 = x16 ? addr_r[18:11] : addr_r[19:12];
  wire [7:0] ab3 = x16 ? addr_r[26:19] : addr_r[27:20];
  wire nbp_uop_s cur = uop_at(op_r, step_r);
  wire [7:0] abyte = (cur.val[1:0] == 2'h0) ? ab0 :
                     (cur.val[1:0] == 2'h1) ? ab1 :
                     (cur.val[1:0] == 2'h2) ? ab2 : ab3;
  wire [15:0] din_bus = x16 ? din_r : {8'h00, din_r[7:0]};
  wire pulse_done = (cnt_r <= 16'h0001);
  wire is_read_op = (op_r == OP_READ) | (op_r == OP_READ_CB);

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      wreq_r <= 1'b1;
      rdata_bus_r <= 32'h0000_0000;
    end else if (i_clk_en) begin
      wreq_r <= ~take;
      if (take && i_avs_read) rdata_bus_r <= rd_mux;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r <= CTRL_RST;
      addr_r <= 28'h000_0000;
      din_r <= 16'h0000;
      refused_r <= 1'b0;
      tmo_r <= 1'b0;
    end else if (i_clk_en) begin
      if (wr_take && idx == REG_CTRL) ctrl_r <= i_avs_writedata[1:0];
      if (wr_take && idx == REG_ADDR) addr_r <= i_avs_writedata[27:0];
      if (dat_wr) din_r <= i_avs_writedata[15:0];
      if (refuse_set) refused_r <= 1'b1;
      else if (stat_wr && i_avs_writedata[ST_REFUSED_BIT]) refused_r <= 1'b0;
      if (state_r == ST_WAITRB && is_read_op && timer_r >= 16'(P_TR_CYC) && !i_rb) tmo_r <= 1'b1;
      else if (stat_wr && i_avs_writedata[ST_TMO_BIT]) tmo_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program bookkeeping
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      loading_r <= 1'b0;
      data_seen_r <= 1'b0;
      cb_r <= 1'b0;
      status_mode_r <= 1'b0;
      prog_cnt_r <= 4'h0;
      last_row_r <= 16'h0000;
    end else if (i_clk_en && start_go) begin
      unique case (start_op)
        OP_PROG, OP_CB_PROG: begin
          loading_r <= 1'b1;
          data_seen_r <= 1'b0;
          cb_r <= (start_op == OP_CB_PROG);
          status_mode_r <= 1'b0;
          last_row_r <= row_w;
          if (row_w != last_row_r) prog_cnt_r <= 4'h0;
        end
        OP_CONFIRM: begin
          loading_r <= 1'b0;
          status_mode_r <= 1'b1;
          prog_cnt_r <= prog_cnt_r + 4'h1;
        end
        OP_ERASE: begin
          loading_r <= 1'b0;
          status_mode_r <= 1'b1;
          prog_cnt_r <= 4'h0;
        end
        OP_STATUS: status_mode_r <= 1'b1;
        OP_DIN: data_seen_r <= 1'b1;
        OP_READ, OP_READ_CB, OP_RAND_OUT: begin
          status_mode_r <= 1'b0;
          loading_r <= 1'b0;
        end
        OP_RAND_IN, OP_READ_WORD: data_seen_r <= data_seen_r;
        default: loading_r <= loading_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin sequencer
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= ST_IDLE;
      pins_r <= PINS_IDLE;
      op_r <= 4'h0;
      step_r <= 4'h0;
      cnt_r <= 16'h0000;
      timer_r <= 16'h0000;
      rdata_r <= 16'h0000;
      nstat_r <= 8'h00;
    end else if (i_clk_en) begin
      pins_r.wp_n <= wp_free;
      unique case (state_r)
        ST_IDLE: begin
          pins_r.ce_n <= 1'b1;
          if (start_go) begin
            op_r <= start_op;
            step_r <= 4'h0;
            pins_r.ce_n <= 1'b0;
            state_r <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          cnt_r <= 16'(PULSE_CYC);
          pins_r.cle <= 1'b0;
          pins_r.ale <= 1'b0;
          pins_r.io_oe <= 1'b0;
          unique case (cur.kind)
            UK_CMD: begin
              pins_r.cle <= 1'b1;
              pins_r.io_oe <= 1'b1;
              pins_r.io <= {8'h00, cur.val};
              pins_r.we_n <= 1'b0;
              state_r <= ST_LOW;
            end
            UK_ADDR: begin
              pins_r.ale <= 1'b1;
              pins_r.io_oe <= 1'b1;
              pins_r.io <= {8'h00, abyte};
              pins_r.we_n <= 1'b0;
              state_r <= ST_LOW;
            end
            UK_DIN: begin
              pins_r.io_oe <= 1'b1;
              pins_r.io <= din_bus;
              pins_r.we_n <= 1'b0;
              state_r <= ST_LOW;
            end
            UK_DOUT: begin
              pins_r.read_strobe_n <= 1'b0;
              state_r <= ST_LOW;
            end
            UK_WAIT: begin
              cnt_r <= 16'(WB_CYC);
              timer_r <= 16'h0000;
              state_r <= ST_BUSYDLY;
            end
            default: begin
              pins_r.ce_n <= 1'b1;
              pins_r.io <= 16'h0000;
              state_r <= ST_IDLE;
            end
          endcase
        end
        ST_LOW: begin
          cnt_r <= cnt_r - 16'h0001;
          if (pulse_done) begin
            cnt_r <= 16'(PULSE_CYC);
            pins_r.we_n <= 1'b1;
            pins_r.read_strobe_n <= 1'b1;
            if (cur.kind == UK_DOUT) begin
              rdata_r <= x16 ? i_io_in : {8'h00, i_io_in[7:0]};
              if (status_mode_r) nstat_r <= i_io_in[7:0];
            end
            state_r <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          cnt_r <= cnt_r - 16'h0001;
          if (pulse_done) begin
            step_r <= step_r + 4'h1;
            state_r <= ST_FETCH;
          end
        end
        ST_BUSYDLY: begin
          cnt_r <= cnt_r - 16'h0001;
          if (pulse_done) state_r <= ST_WAITRB;
        end
        ST_WAITRB: begin
          if (timer_r != 16'hffff) timer_r <= timer_r + 16'h0001;
          if (i_rb) begin
            step_r <= step_r + 4'h1;
            state_r <= ST_FETCH;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_nand = pins_r;
  assign o_avs_readdata = rdata_bus_r;
  assign o_avs_waitrequest = wreq_r;

endmodule : nbp_host

// ### dv/nbp_host_checker.sv
// Bus-timing assertions for the NAND host controller
`timescale 1ns/1ps
module nbp_host_checker import nbp_pkg::*; #(
  parameter int P_TR_CYC = ARRAY_TRANSFER_CYC
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire nbp_pins_s o_nand,
  input wire logic [15:0] i_io_in,
  input wire logic i_rb
);
  default clocking dc @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////////
  // Strobe pulse shapes
  sequence s_we_low;
    (!o_nand.we_n) [*4];
  endsequence
  sequence s_re_low;
    (!o_nand.read_strobe_n) [*4];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  // Pin relations
  AST_CMD_FRAME: assert property (
    $rose(o_nand.we_n) && o_nand.cle |-> !o_nand.ale && !o_nand.ce_n && o_nand.read_strobe_n)
    else $error("command latched outside its frame");
  AST_ADDR_FRAME: assert property (
    $rose(o_nand.we_n) && o_nand.ale |-> !o_nand.cle && !o_nand.ce_n && o_nand.read_strobe_n)
    else $error("address latched outside its frame");
  AST_LOW_LINES: assert property (
    !o_nand.we_n && (o_nand.cle || o_nand.ale) |-> o_nand.io_oe && o_nand.io[15:8] == 8'h00)
    else $error("command or address not on low lines");
  AST_DIN_FRAME: assert property (
    $rose(o_nand.we_n) && !o_nand.cle && !o_nand.ale |-> o_nand.wp_n && !o_nand.ce_n)
    else $error("data word latched while protected");
  AST_MODIFY_WP: assert property (
    $rose(o_nand.we_n) && o_nand.cle && o_nand.io[7:0] inside {8'h80, 8'h85, 8'h10, 8'h60, 8'hd0}
    |-> o_nand.wp_n)
    else $error("modify command with protect low");
  AST_DOUT_FRAME: assert property (
    !o_nand.read_strobe_n |-> o_nand.we_n && !o_nand.cle && !o_nand.ale && !o_nand.ce_n && !o_nand.io_oe)
    else $error("read strobe outside output frame");
  AST_WE_PULSE: assert property (
    $fell(o_nand.we_n) |-> s_we_low ##[1:2] o_nand.we_n)
    else $error("write strobe pulse malformed");
  AST_RE_PULSE: assert property (
    $fell(o_nand.read_strobe_n) |-> s_re_low ##[1:2] o_nand.read_strobe_n)
    else $error("read strobe pulse malformed");
  AST_BUSY_QUIET: assert property (
    $fell(o_nand.we_n) || $fell(o_nand.read_strobe_n) |-> i_rb)
    else $error("strobe while device busy");
endmodule : nbp_host_checker
bind nbp_host nbp_host_checker #(.P_TR_CYC(P_TR_CYC)) u_chk (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_clk_en(i_clk_en), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_nand(o_nand),
  .i_io_in(i_io_in), .i_rb(i_rb));

// ### dv/nbp_flash_model.sv
// Behavioural x8 NAND flash device for the host bench
`timescale 1ns/1ps
module nbp_flash_model import nbp_pkg::*; #(
  parameter int P_BUSY_NS = 150
) (
  input wire nbp_pins_s i_pins,
  output logic [15:0] o_io,
  output logic o_rb
);
  logic [7:0] mem [logic [27:0]];
  logic [7:0] pbuf [logic [11:0]];
  logic [27:0] dq [$];
  logic [7:0] cmd;
  logic [7:0] dout = 8'h00;
  logic [11:0] col = 12'h000;
  logic [15:0] row = 16'h0000;
  logic smode = 1'b0;
  logic loading = 1'b0;
  logic cb = 1'b0;
  int acnt = 0;
  int dcnt = 0;
  int cmd_cnt = 0;
  event go;
  initial o_rb = 1'b1;
  // Released lines show the inverse of the last value
  assign o_io = (!i_pins.ce_n && !i_pins.read_strobe_n) ? {8'h00, dout} : ~{8'h00, dout};
  always @(go) begin
    o_rb = 1'b0;
    #(P_BUSY_NS);
    o_rb = 1'b1;
  end
  function automatic logic [7:0] rd(input logic [27:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction : rd
  ////////////////////////////////////////////////////////////////////////////
  // Write strobe decoding
  always @(posedge i_pins.we_n) if (!i_pins.ce_n) begin
    if (i_pins.cle) begin
      cmd = i_pins.io[7:0];
      cmd_cnt++;
      if ((o_rb || cmd == 8'h70) && (i_pins.wp_n || !(cmd inside {8'h80, 8'h85, 8'h10, 8'h60, 8'hd0}))) begin
        case (cmd)
          8'h00, 8'h05: begin
            acnt = 0;
            smode = 1'b0;
          end
          8'h30, 8'h35: begin
            cb = cmd[0];
            pbuf.delete();
            foreach (mem[a]) if (a[27:12] == row) pbuf[a[11:0]] = mem[a];
            -> go;
          end
          8'h80: begin
            pbuf.delete();
            {acnt, dcnt, cb, smode, loading} = {32'd0, 32'd0, 3'b001};
          end
          8'h85: {acnt, loading} = {32'd0, 1'b1};
          8'h10: if (loading && (dcnt > 0 || cb)) begin
            foreach (pbuf[c]) mem[{row, c}] = rd({row, c}) & pbuf[c];
            {loading, smode} = 2'b01;
            -> go;
          end
          8'h60: acnt = 2;
          8'hd0: begin
            foreach (mem[a]) if (a[27:18] == row[15:6]) dq.push_back(a);
            foreach (dq[i]) mem.delete(dq[i]);
            dq.delete();
            smode = 1'b1;
            -> go;
          end
          8'h70: smode = 1'b1;
          default: ;
        endcase
      end
    end else if (i_pins.ale) begin
      case (acnt)
        0: col[7:0] = i_pins.io[7:0];
        1: col[11:8] = i_pins.io[3:0];
        2: row[7:0] = i_pins.io[7:0];
        default: row[15:8] = i_pins.io[7:0];
      endcase
      acnt++;
    end else if (i_pins.wp_n && loading) begin
      pbuf[col] = i_pins.io[7:0];
      col++;
      dcnt++;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Read strobe output
  always @(negedge i_pins.read_strobe_n) if (!i_pins.ce_n) begin
    dout = smode ? {1'b0, o_rb, 6'h00} : rd({row, col});
    if (!smode) col++;
  end
endmodule : nbp_flash_model

// ### dv/nbp_host_tb.sv
// Self-checking bench for the NAND bus host controller
`timescale 1ns/1ps
module nbp_host_tb import nbp_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  int cc = 0;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic wreq;
  nbp_pins_s pins;
  logic [15:0] m_io;
  logic [15:0] io_in;
  logic rb;
  int error_cnt = 0;
  int comparisons = 0;
  always #2.5 clk = ~clk;
  assign io_in = pins.io_oe ? pins.io : m_io;
  nbp_host #(.P_TR_CYC(50)) uut (.i_clock(clk), .i_rstn(rstn), .i_clk_en(clk_en), .i_avs_address(adr),
    .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wd), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_nand(pins), .i_io_in(io_in), .i_rb(rb));
  nbp_flash_model #(.P_BUSY_NS(150)) u_flash (.i_pins(pins), .o_io(m_io), .o_rb(rb));
  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr_s <= w;
    rd_s <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 40000);
    if (wreq !== 1'b0) begin
      error_cnt++;
      end_of_test();
    end
    q = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask : xfer
  // Polls status until the pin sequencer is idle
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      xfer(1'b0, 5'h10, 32'h0);
      k++;
    end while (q[ST_BUSY_BIT] !== 1'b0 && k < 4000);
    if (q[ST_BUSY_BIT] !== 1'b0) begin
      error_cnt++;
      end_of_test();
    end
  endtask : wait_idle
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    wait_idle();
    xfer(1'b0, a, 32'h0);
    check(q, exp);
  endtask : rdc
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #300us;
    error_cnt++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rdc(5'h10, 32'h2);
    rdc(5'h1c, 32'h0);
    check({31'h0, pins.wp_n}, 32'h0);
    wr(5'h04, OP_PROG);
    rdc(5'h10, 32'h6);
    check(u_flash.cmd_cnt, 0);
    wr(5'h10, 32'h4);
    $display("done: protect");
    wr(5'h00, 32'h1);
    wr(5'h08, 32'h0042004);
    wr(5'h04, OP_PROG);
    for (int i = 0; i < 3; i++) wr(5'h0c, 32'ha0 + i);
    wr(5'h04, OP_CONFIRM);
    rdc(5'h10, 32'h4002);
    for (int i = 0; i < 3; i++) check(u_flash.rd(28'h0042004 + i), 32'ha0 + i);
    wr(5'h04, OP_CONFIRM);
    rdc(5'h10, 32'h4006);
    wr(5'h10, 32'h4);
    $display("done: program");
    wr(5'h04, OP_READ);
    for (int i = 0; i < 3; i++) begin
      wr(5'h04, OP_READ_WORD);
      rdc(5'h0c, 32'ha0 + i);
    end
    wr(5'h08, 32'h0042004);
    wr(5'h04, OP_RAND_OUT);
    wr(5'h04, OP_READ_WORD);
    rdc(5'h0c, 32'ha0);
    $display("done: read");
    wr(5'h08, 32'h0042010);
    wr(5'h04, OP_PROG);
    wr(5'h0c, 32'h11);
    wr(5'h08, 32'h0042020);
    wr(5'h04, OP_RAND_IN);
    wr(5'h0c, 32'h22);
    wr(5'h04, OP_CONFIRM);
    wait_idle();
    check(u_flash.rd(28'h0042010), 32'h11);
    check(u_flash.rd(28'h0042020), 32'h22);
    $display("done: random input");
    wr(5'h08, 32'h0042000);
    wr(5'h04, OP_READ_CB);
    wr(5'h08, 32'h0080000);
    wr(5'h04, OP_CB_PROG);
    wr(5'h04, OP_CONFIRM);
    wait_idle();
    check(u_flash.rd(28'h0080005), 32'ha1);
    check(u_flash.rd(28'h0080020), 32'h22);
    $display("done: copy-back");
    for (int i = 0; i < 9; i++) begin
      wr(5'h08, 32'h0043000 + i);
      wr(5'h04, OP_PROG);
      wr(5'h0c, 32'h5a);
      wr(5'h04, OP_CONFIRM);
    end
    rdc(5'h10, 32'h4006);
    check(u_flash.rd(28'h0043008), 32'hff);
    wr(5'h10, 32'h4);
    $display("done: partial limit");
    wr(5'h08, 32'h0042000);
    wr(5'h04, OP_ERASE);
    wait_idle();
    check(u_flash.rd(28'h0042004), 32'hff);
    check(u_flash.rd(28'h0080004), 32'ha0);
    wr(5'h00, 32'h0);
    wr(5'h08, 32'h0080000);
    wr(5'h04, OP_ERASE);
    wait_idle();
    check(u_flash.rd(28'h0080004), 32'ha0);
    rdc(5'h10, 32'h4006);
    $display("done: erase");
    // Clock enable low holds a pending command off the pins
    cc = u_flash.cmd_cnt;
    @(posedge clk);
    clk_en <= 1'b0;
    adr <= 5'h04;
    wd <= 32'(OP_STATUS);
    wr_s <= 1'b1;
    repeat (20) @(posedge clk);
    check({31'h0, wreq}, 32'h1);
    check(u_flash.cmd_cnt, cc);
    clk_en <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    wr_s <= 1'b0;
    rdc(5'h10, 32'h4006);
    check(u_flash.cmd_cnt, cc + 1);
    $display("done: clock enable");
    end_of_test();
  end
endmodule : nbp_host_tb
